// ---- pmv_pkg.sv ----
// Constants, register map and types for the pair mix and volume block
package pmv_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PMV_MODE3_OFS = 8'h03;
  localparam logic [7:0] PMV_ID_OFS = 8'h12;
  // Mixing control, pair 1..3 at index 0..2
  localparam logic [2:0][7:0] PMV_MIX_OFS = {8'h0c, 8'h09, 8'h06};
  // Volume A1,B1,A2,B2,A3,B3 at index 0..5
  localparam logic [5:0][7:0] PMV_VOL_OFS =
    {8'h0e, 8'h0d, 8'h0b, 8'h0a, 8'h08, 8'h07};

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PMV_MODE3_RST = 8'h84;
  localparam logic [7:0] PMV_MIX_RST = 8'h24;
  localparam logic [7:0] PMV_VOL_RST = 8'h00;
  localparam logic [1:0] PMV_SPEED_RST = 2'h0;
  localparam logic [1:0] PMV_SPEED_ONEBIT = 2'h3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PMV_STYLE_LSB = 6;
  localparam int PMV_GLOBAL_GANG_BIT = 5;
  localparam int PMV_MUTEPOL_BIT = 3;
  localparam int PMV_MUTEROUTE_LSB = 0;
  localparam int PMV_PAIR_GANG_BIT = 7;
  localparam int PMV_MIXSEL_LSB = 2;
  localparam int PMV_SPEED_LSB = 0;
  localparam int PMV_SILENCE_BIT = 7;
  localparam int PMV_PART_LSB = 3;

  // ----------------------------------------------------------------
  // Level tracking, in eighths of a dB
  // ----------------------------------------------------------------
  localparam int PMV_STEPS_PER_DB = 8;
  localparam logic [10:0] PMV_LEVEL_MUTE = 11'h400;
  localparam int PMV_ZC_TIMEOUT_FRAMES = 512;

  // Transition style of level changes
  typedef enum logic [1:0] {
    PMV_IMMEDIATE,
    PMV_ZERO_CROSS,
    PMV_SOFT_RAMP,
    PMV_SOFT_ZERO_CROSS
  } pmv_style_e;

  // Mute pin routing
  typedef enum logic [1:0] {
    PMV_PINS_SIX,
    PMV_PINS_ONE_A,
    PMV_PINS_ONE_B,
    PMV_PINS_THREE
  } pmv_route_e;

endpackage : pmv_pkg

// ---- pmv_level_track.sv ----
// Per-channel level tracker: soft ramp and zero-cross timing
`timescale 1ns/10ps
module pmv_level_track
  import pmv_pkg::*;
#(
  parameter int SAMPLE_W = 24
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic frameStb,
  input wire logic [1:0] transStyle,
  input wire logic [10:0] targetLevel,
  input wire logic signed [SAMPLE_W-1:0] sampleNow,
  output logic [10:0] curLevel
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [10:0] level_ff;
  logic [10:0] nxt_level;
  logic [9:0] waitCnt_ff;
  logic [9:0] nxt_waitCnt;
  logic prevNeg_ff;
  logic applyNow;
  pmv_style_e style;

  assign style = pmv_style_e'(transStyle);

  // Zero crossing seen against the previous frame's sign
  wire pending = level_ff != targetLevel;
  wire zeroCross = (sampleNow == '0) ||
                   (sampleNow[SAMPLE_W-1] != prevNeg_ff);
  wire timedOut = waitCnt_ff == 10'(PMV_ZC_TIMEOUT_FRAMES - 1);
  wire zcGate = zeroCross || timedOut;
  // One eighth of a dB per frame gives 1 dB per 8 frames
  wire [10:0] stepLevel = (level_ff < targetLevel) ?
                          level_ff + 11'h001 : level_ff - 11'h001;

  // Next level by transition style
  always_comb
  begin
    nxt_level = level_ff;
    applyNow = 1'b0;
    if (frameStb && pending)
    begin
      case (style)
        PMV_IMMEDIATE:
        begin
          applyNow = 1'b1;
          nxt_level = targetLevel;
        end
        PMV_ZERO_CROSS:
        begin
          applyNow = zcGate;
          nxt_level = zcGate ? targetLevel : level_ff;
        end
        PMV_SOFT_RAMP:
        begin
          applyNow = 1'b1;
          nxt_level = stepLevel;
        end
        PMV_SOFT_ZERO_CROSS:
        begin
          applyNow = zcGate;
          nxt_level = zcGate ? stepLevel : level_ff;
        end
        default:
        begin
          applyNow = 1'b1;
          nxt_level = targetLevel;
        end
      endcase
    end
  end

  // Timeout restarts after every applied step, 512 frames at most
  always_comb
  begin
    nxt_waitCnt = waitCnt_ff;
    if (!pending)
      nxt_waitCnt = '0;
    else if (frameStb)
      nxt_waitCnt = applyNow ? '0 : waitCnt_ff + 10'h001;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_ff <= 11'h000;
      waitCnt_ff <= 10'h000;
      prevNeg_ff <= 1'b0;
    end
    else
    begin
      level_ff <= nxt_level;
      waitCnt_ff <= nxt_waitCnt;
      if (frameStb)
        prevNeg_ff <= sampleNow[SAMPLE_W-1];
    end
  end

  assign curLevel = level_ff;

endmodule : pmv_level_track

// ---- pmv_mix_volume.sv ----
// Pair mixing, speed mode, per-channel volume and mute, register file
//
// Function
// - Each pair has a five-bit mix selector, reset giving left-to-A, right-to-B.
// - Top bit clear: low bits pick B, next bits pick A: mute/R/L/avg.
// - Top bit is not decoded: set or clear, A and B pick mute/R/L/avg as above.
// - Two-bit speed field per pair: single, double, quad, one-bit stream.
// - Speed change other than into one-bit stream takes effect only once all three pairs agree.
// - Any pair selecting one-bit stream forces all pairs into it.
// - Six volume registers at 07h..0Eh: mute bit 7, attenuation bits 6..0.
// - A silenced channel holds the quiescent midscale output.
// - Entering and leaving silence follows the selected transition style.
// - Silenced channels drive mute pins per routing field and polarity.
// - Attenuation code N applies N dB in 1 dB steps, 0 to 127.
// - Attenuation changes follow the selected transition style.
// - Attenuation stops at 127 dB; only the silence bit reaches mute.
// - Volume registers reset to zero: no attenuation, no silence.
// - Read-only ID at 12h: part code bits 7..3, revision 2..0.
// - Pair gang makes both pair outputs use channel A's volume.
// - Global gang makes all six channels use channel A1's volume.
// - Soft ramp steps 1/8 dB toward target, 1 dB per 8 frames.
// - Zero-cross modes wait per channel, timeout 512 frames.
`timescale 1ns/10ps
module pmv_mix_volume
  import pmv_pkg::*;
#(
  parameter int SAMPLE_W = 24,
  parameter logic [4:0] PART_CODE = 5'h13,  // Arbitrary value
  parameter logic [2:0] REV_CODE = 3'h5     // Arbitrary value
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic frameStb,
  input wire logic [2:0][SAMPLE_W-1:0] pairLeft,
  input wire logic [2:0][SAMPLE_W-1:0] pairRight,
  output logic [2:0][SAMPLE_W-1:0] pair_output_a,
  output logic [2:0][SAMPLE_W-1:0] pair_output_b,
  output logic [5:0] mutePin,
  output logic [1:0] speed_range_select,
  output logic one_bit_stream_mode
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (SAMPLE_W < 8 || SAMPLE_W > 32)
  begin : gBadWidth
    $error("SAMPLE_W must lie between 8 and 32");
  end

  // ----------------------------------------------------------------
  // Gain tables, Q16 fine and mid steps, Q30 coarse steps
  // ----------------------------------------------------------------
  // Eighth-dB steps inside one dB
  function automatic logic [16:0] fineGain(input logic [2:0] f);
    case (f)
      3'h0: fineGain = 17'd65536;
      3'h1: fineGain = 17'd64600;
      3'h2: fineGain = 17'd63677;
      3'h3: fineGain = 17'd62768;
      3'h4: fineGain = 17'd61870;
      3'h5: fineGain = 17'd60986;
      3'h6: fineGain = 17'd60115;
      default: fineGain = 17'd59256;
    endcase
  endfunction : fineGain

  // Whole dB steps 0..15
  function automatic logic [16:0] midGain(input logic [3:0] k);
    case (k)
      4'h0: midGain = 17'd65536;
      4'h1: midGain = 17'd58409;
      4'h2: midGain = 17'd52057;
      4'h3: midGain = 17'd46396;
      4'h4: midGain = 17'd41350;
      4'h5: midGain = 17'd36854;
      4'h6: midGain = 17'd32846;
      4'h7: midGain = 17'd29274;
      4'h8: midGain = 17'd26090;
      4'h9: midGain = 17'd23253;
      4'ha: midGain = 17'd20724;
      4'hb: midGain = 17'd18471;
      4'hc: midGain = 17'd16462;
      4'hd: midGain = 17'd14672;
      4'he: midGain = 17'd13076;
      default: midGain = 17'd11654;
    endcase
  endfunction : midGain

  // Sixteen-dB steps 0..112 dB; Q30 keeps precision near -127 dB
  function automatic logic [30:0] coarseGain(input logic [2:0] j);
    case (j)
      3'h0: coarseGain = 31'd1073741824;
      3'h1: coarseGain = 31'd170176790;
      3'h2: coarseGain = 31'd26971150;
      3'h3: coarseGain = 31'd4274563;
      3'h4: coarseGain = 31'd677481;
      3'h5: coarseGain = 31'd107374;
      3'h6: coarseGain = 31'd17018;
      default: coarseGain = 31'd2697;
    endcase
  endfunction : coarseGain

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] modeReg_ff;
  logic [2:0][7:0] mixReg_ff;
  logic [5:0][7:0] volReg_ff;
  logic [7:0] rdData_ff;
  logic [7:0] nxt_rdData;
  logic [1:0] speed_ff;
  logic [1:0] nxt_speed;
  logic [5:0] mutePin_ff;
  logic [5:0] nxt_mutePin;

  // Address decode; the ID offset has no write strobe at all
  wire modeHit = regAddr == PMV_MODE3_OFS;
  wire idHit = regAddr == PMV_ID_OFS;
  logic [2:0] mixHit;
  logic [5:0] volHit;

  for (genvar p = 0; p < 3; p++)
  begin : gMixDec
    assign mixHit[p] = regAddr == PMV_MIX_OFS[p];
  end
  for (genvar c = 0; c < 6; c++)
  begin : gVolDec
    assign volHit[c] = regAddr == PMV_VOL_OFS[c];
  end

  // Control writes
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      modeReg_ff <= PMV_MODE3_RST;
      mixReg_ff <= {3{PMV_MIX_RST}};
      volReg_ff <= {6{PMV_VOL_RST}};
    end
    else if (regWrEn)
    begin
      if (modeHit)
        modeReg_ff <= regWrData;
      for (int p = 0; p < 3; p++)
        if (mixHit[p])
          mixReg_ff[p] <= regWrData;
      for (int c = 0; c < 6; c++)
        if (volHit[c])
          volReg_ff[c] <= regWrData;
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    nxt_rdData = 8'h00;
    if (modeHit)
      nxt_rdData = modeReg_ff;
    if (idHit)
      nxt_rdData = {PART_CODE, REV_CODE};
    for (int p = 0; p < 3; p++)
      if (mixHit[p])
        nxt_rdData = mixReg_ff[p];
    for (int c = 0; c < 6; c++)
      if (volHit[c])
        nxt_rdData = volReg_ff[c];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdData_ff <= 8'h00;
    else if (regRdEn)
      rdData_ff <= nxt_rdData;
  end

  assign regRdData = rdData_ff;

  // ----------------------------------------------------------------
  // Speed mode
  // ----------------------------------------------------------------
  wire [1:0] spd0 = mixReg_ff[0][PMV_SPEED_LSB +: 2];
  wire [1:0] spd1 = mixReg_ff[1][PMV_SPEED_LSB +: 2];
  wire [1:0] spd2 = mixReg_ff[2][PMV_SPEED_LSB +: 2];
  wire anyOneBit = (spd0 == PMV_SPEED_ONEBIT) ||
                   (spd1 == PMV_SPEED_ONEBIT) ||
                   (spd2 == PMV_SPEED_ONEBIT);
  wire allAgree = (spd0 == spd1) && (spd1 == spd2);

  // Disagreeing fields without a one-bit request leave the running rate untouched
  assign nxt_speed = anyOneBit ? PMV_SPEED_ONEBIT :
                     allAgree ? spd0 : speed_ff;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      speed_ff <= PMV_SPEED_RST;
    else
      speed_ff <= nxt_speed;
  end

  assign speed_range_select = speed_ff;
  assign one_bit_stream_mode = speed_ff == PMV_SPEED_ONEBIT;

  // ----------------------------------------------------------------
  // Per-channel mixing and volume
  // ----------------------------------------------------------------
  wire globalGang = modeReg_ff[PMV_GLOBAL_GANG_BIT];
  wire [1:0] transStyle = modeReg_ff[PMV_STYLE_LSB +: 2];
  logic [5:0] chanSilent;

  for (genvar c = 0; c < 6; c++)
  begin : gChan
    localparam int P = c / 2;
    localparam bit IS_A = (c % 2) == 0;

    logic signed [SAMPLE_W-1:0] mixed;
    logic signed [SAMPLE_W-1:0] out_ff;
    logic [10:0] curLevel;

    // Full-precision sum then halve, so the mean never overflows
    wire signed [SAMPLE_W:0] sumLR = $signed({pairLeft[P][SAMPLE_W-1],
      pairLeft[P]}) + $signed({pairRight[P][SAMPLE_W-1], pairRight[P]});
    wire signed [SAMPLE_W-1:0] avgLR = sumLR[SAMPLE_W:1];
    wire [4:0] sel = mixReg_ff[P][PMV_MIXSEL_LSB +: 5];
    wire [1:0] code = IS_A ? sel[3:2] : sel[1:0];
    wire mixMute = code == 2'h0;

    // Each channel's mean draws on this pair's own left and right
    always_comb
    begin
      case (code)
        2'h1: mixed = $signed(pairRight[P]);
        2'h2: mixed = $signed(pairLeft[P]);
        2'h3: mixed = avgLR;
        default: mixed = '0;
      endcase
    end

    // Gang selection of the governing volume register
    wire [7:0] effVol = globalGang ? volReg_ff[0] :
      mixReg_ff[P][PMV_PAIR_GANG_BIT] ? volReg_ff[2*P] :
      volReg_ff[c];
    wire silenceBit = effVol[PMV_SILENCE_BIT];
    // Seven bits cannot exceed 127 dB, so only the bit reaches mute
    wire [10:0] targetLevel = silenceBit ? PMV_LEVEL_MUTE :
      11'({effVol[6:0], 3'h0});

    pmv_level_track #(
      .SAMPLE_W(SAMPLE_W)
    ) uTrack (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .frameStb(frameStb),
      .transStyle(transStyle),
      .targetLevel(targetLevel),
      .sampleNow(mixed),
      .curLevel(curLevel)
    );

    // Level to linear gain: coarse x mid x fine
    wire [7:0] levelDb = curLevel[10:3];
    wire [47:0] prodCm = coarseGain(levelDb[6:4]) * midGain(levelDb[3:0]);
    wire [30:0] gainCm = prodCm[46:16];
    wire [47:0] prodAll = gainCm * fineGain(curLevel[2:0]);
    wire [30:0] gainQ30 = prodAll[46:16];
    wire signed [SAMPLE_W+31:0] scaled = mixed * $signed({1'b0, gainQ30});
    wire levelMuted = curLevel >= PMV_LEVEL_MUTE;

    // Silence holds midscale rather than releasing the output
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
        out_ff <= '0;
      else if (frameStb)
        out_ff <= (levelMuted || mixMute) ? '0 :
                  scaled[SAMPLE_W+29:30];
    end

    assign chanSilent[c] = silenceBit;
    if (IS_A)
    begin : gOutA
      assign pair_output_a[P] = out_ff;
    end
    else
    begin : gOutB
      assign pair_output_b[P] = out_ff;
    end
  end

  // ----------------------------------------------------------------
  // Mute pins
  // ----------------------------------------------------------------
  pmv_route_e route;
  assign route = pmv_route_e'(modeReg_ff[PMV_MUTEROUTE_LSB +: 2]);
  wire activeLow = modeReg_ff[PMV_MUTEPOL_BIT];

  // Grouped pins assert only when every channel they cover is silent
  always_comb
  begin
    nxt_mutePin = 6'h00;
    case (route)
      PMV_PINS_SIX: nxt_mutePin = chanSilent;
      PMV_PINS_ONE_A, PMV_PINS_ONE_B:
        nxt_mutePin[0] = &chanSilent;
      PMV_PINS_THREE:
      begin
        nxt_mutePin[0] = &chanSilent[1:0];
        nxt_mutePin[1] = &chanSilent[3:2];
        nxt_mutePin[2] = &chanSilent[5:4];
      end
      default: nxt_mutePin = chanSilent;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      mutePin_ff <= 6'h00;
    else
      mutePin_ff <= nxt_mutePin ^ {6{activeLow}};
  end

  assign mutePin = mutePin_ff;

endmodule : pmv_mix_volume

// ---- pmv_mix_volume_asserts.sv ----
// Port-level checks for the pair mix and volume block
`timescale 1ns/10ps
module pmv_chk
  import pmv_pkg::*;
#(
  parameter int SAMPLE_W = 24,
  parameter logic [4:0] PART_CODE = 5'h13,
  parameter logic [2:0] REV_CODE = 3'h5
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic frameStb,
  input wire logic [2:0][SAMPLE_W-1:0] pairLeft,
  input wire logic [2:0][SAMPLE_W-1:0] pairRight,
  input wire logic [2:0][SAMPLE_W-1:0] pair_output_a,
  input wire logic [2:0][SAMPLE_W-1:0] pair_output_b,
  input wire logic [5:0] mutePin,
  input wire logic [1:0] speed_range_select,
  input wire logic one_bit_stream_mode
);
  // ----
  // Single domain, so one clocking and one disable
  // ----
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  idCode_a:
    assert property (regRdEn && regAddr == PMV_ID_OFS |=>
      regRdData == {PART_CODE, REV_CODE}) else $error("id read wrong");
  unmappedRead_a:
    assert property (regRdEn && regAddr == 8'h01 |=> regRdData == 8'h00)
      else $error("unmapped read not zero");
  readHold_a:
    assert property (!regRdEn |=> $stable(regRdData))
      else $error("read data moved without a read");
  oneBitFlag_a:
    assert property (one_bit_stream_mode ==
      (speed_range_select == PMV_SPEED_ONEBIT)) else $error("stream flag");
  speedCause_a:
    assert property ($changed(speed_range_select) |-> $past(regWrEn, 2))
      else $error("speed moved without a write");
  outHold_a:
    assert property (!frameStb |=> $stable(pair_output_a) &&
      $stable(pair_output_b)) else $error("output moved between frames");
  volBack_a:
    assert property (regWrEn && regAddr == PMV_VOL_OFS[4] ##1 !regWrEn ##1
      regRdEn && !regWrEn && regAddr == PMV_VOL_OFS[4] |=>
      regRdData == $past(regWrData, 3)) else $error("volume readback");
  muteCause_a:
    assert property ($changed(mutePin) |-> $past(regWrEn, 2))
      else $error("mute pins moved without a write");
endmodule : pmv_chk

bind pmv_mix_volume pmv_chk #(
  .SAMPLE_W(SAMPLE_W), .PART_CODE(PART_CODE), .REV_CODE(REV_CODE)
) pmv_chk_inst (
  .core_clk(core_clk), .rst_n(rst_n), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
  .regRdData(regRdData), .frameStb(frameStb), .pairLeft(pairLeft),
  .pairRight(pairRight), .pair_output_a(pair_output_a),
  .pair_output_b(pair_output_b), .mutePin(mutePin),
  .speed_range_select(speed_range_select),
  .one_bit_stream_mode(one_bit_stream_mode)
);

// ---- pmv_audio_src.sv ----
// Sample source model feeding all three pairs
`timescale 1ns/10ps
module pmv_audio_src
#(
  parameter int SAMPLE_W = 24,
  parameter int FRAME_CYC = 4
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [SAMPLE_W-1:0] leftVal,
  input wire logic [SAMPLE_W-1:0] rightVal,
  output logic frameStb,
  output logic [2:0][SAMPLE_W-1:0] pairLeft,
  output logic [2:0][SAMPLE_W-1:0] pairRight
);
  int cnt = 0;
  logic go;

  assign go = rst_n && cnt == 0;

  // Lines carry a moving junk pattern outside the strobe cycle, so a
  // design sampling at the wrong edge cannot pass by luck
  always @(negedge core_clk)
  begin
    cnt <= (cnt == FRAME_CYC - 1) ? 0 : cnt + 1;
    frameStb <= go;
    pairLeft <= go ? {3{leftVal}} : {3{~leftVal ^ SAMPLE_W'(cnt)}};
    pairRight <= go ? {3{rightVal}} : {3{~rightVal ^ SAMPLE_W'(cnt)}};
  end

  initial
  begin
    frameStb = 1'b0;
    pairLeft = '0;
    pairRight = '0;
  end
endmodule : pmv_audio_src

// ---- testbench.sv ----
// Self-checking bench for the pair mix and volume block
`timescale 1ns/10ps
module testbench;
  import pmv_pkg::*;
  localparam int SW = 24;
  localparam logic [4:0] PART = 5'h13; // Arbitrary value
  localparam logic [2:0] SILICON_REVISION_CODE = 3'h5; // Arbitrary value
  typedef struct {logic [4:0] sel; int a; int b;} pmv_row_s;
  // Left is 1000, right 3000, so any mean is 2000
  pmv_row_s rows[8] = '{'{5'h09, 1000, 3000}, '{5'h00, 0, 0},
    '{5'h06, 3000, 1000}, '{5'h0f, 2000, 2000}, '{5'h17, 3000, 2000},
    '{5'h1e, 2000, 1000}, '{5'h13, 0, 2000}, '{5'h1c, 2000, 0}};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic frameStb;
  logic [2:0][SW-1:0] pairLeft, pairRight, outA, outB;
  logic [5:0] mutePin;
  logic [1:0] speed;
  logic oneBit;
  logic [SW-1:0] rightVal = 24'd3000;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;

  always #5 core_clk = ~core_clk;

  pmv_audio_src #(.SAMPLE_W(SW)) pmv_audio_src_inst (.core_clk(core_clk),
    .rst_n(rst_n), .leftVal(24'd1000), .rightVal(rightVal),
    .frameStb(frameStb), .pairLeft(pairLeft), .pairRight(pairRight));

  pmv_mix_volume #(.SAMPLE_W(SW), .PART_CODE(PART), .REV_CODE(SILICON_REVISION_CODE))
    pmv_mix_volume_inst (.core_clk(core_clk), .rst_n(rst_n),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .frameStb(frameStb),
    .pairLeft(pairLeft), .pairRight(pairRight), .pair_output_a(outA),
    .pair_output_b(outB), .mutePin(mutePin), .speed_range_select(speed),
    .one_bit_stream_mode(oneBit));

  // ----
  // Bus and compare helpers, entered at a falling edge
  // ----
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chkReg

  // Gain is a table approximation, hence the tolerance
  task automatic chkSmp(input logic [SW-1:0] got, input int exp, int tol);
    logic signed [SW-1:0] g;
    g = got;
    n_checks++;
    if ($isunknown(got) || int'(g) - exp > tol || exp - int'(g) > tol)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chkSmp

  // Idle cycle after each access, so a strobe never drops and rises at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge core_clk);
    regWrEn = 1'b0;
    @(negedge core_clk);
  endtask : wr

  // Write, then let the registered side effects land
  task automatic wrs(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    @(negedge core_clk);
  endtask : wrs

  task automatic chkRd(input logic [7:0] a, input logic [7:0] exp);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge core_clk);
    regRdEn = 1'b0;
    chkReg(regRdData, exp);
    @(negedge core_clk);
  endtask : chkRd

  task automatic frames(input int n);
    repeat (n) @(posedge core_clk iff frameStb === 1'b1);
    @(negedge core_clk);
  endtask : frames

  // ----
  // Main sequence
  // ----
  initial
  begin
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    for (int p = 0; p < 3; p++) chkRd(PMV_MIX_OFS[p], 8'h24);
    for (int c = 0; c < 6; c++) chkRd(PMV_VOL_OFS[c], 8'h00);
    wr(PMV_ID_OFS, 8'h00);
    chkRd(PMV_ID_OFS, {PART, SILICON_REVISION_CODE});
    chkRd(8'h01, 8'h00);
    wr(PMV_VOL_OFS[4], 8'h5a);
    chkRd(PMV_VOL_OFS[4], 8'h5a);
    wr(PMV_VOL_OFS[4], 8'h00);
    wr(PMV_MODE3_OFS, 8'h00);
    // Mixing table, spread over the three pairs
    for (int i = 0; i < 8; i++)
    begin
      wr(PMV_MIX_OFS[i % 3], {1'b0, rows[i].sel, 2'b00});
      frames(2);
      chkSmp(outA[i % 3], rows[i].a, 2);
      chkSmp(outB[i % 3], rows[i].b, 2);
    end
    for (int p = 0; p < 3; p++) wr(PMV_MIX_OFS[p], 8'h24);
    // Silence bit, pin routing, polarity and global gang
    wrs(PMV_VOL_OFS[0], 8'h80);
    chkReg({2'b00, mutePin}, 8'h01);
    frames(2);
    chkSmp(outA[0], 0, 0);
    chkSmp(outB[0], 3000, 2);
    wrs(PMV_MODE3_OFS, 8'h20);
    chkReg({2'b00, mutePin}, 8'h3f);
    frames(2);
    chkSmp(outB[2], 0, 0);
    wrs(PMV_MODE3_OFS, 8'h21);
    chkReg({2'b00, mutePin}, 8'h01);
    wrs(PMV_MODE3_OFS, 8'h23);
    chkReg({2'b00, mutePin}, 8'h07);
    wrs(PMV_MODE3_OFS, 8'h2b);
    chkReg({2'b00, mutePin}, 8'h38);
    wr(PMV_MODE3_OFS, 8'h00);
    wrs(PMV_VOL_OFS[0], 8'h00);
    chkReg({2'b00, mutePin}, 8'h00);
    // Attenuation codes and pair gang
    wr(PMV_VOL_OFS[1], 8'd20);
    frames(2);
    chkSmp(outB[0], 300, 2);
    wr(PMV_VOL_OFS[1], 8'h7f);
    frames(2);
    chkSmp(outB[0], 0, 1);
    wr(PMV_MIX_OFS[0], 8'ha4);
    frames(2);
    chkSmp(outB[0], 3000, 2);
    wr(PMV_MIX_OFS[0], 8'h24);
    wr(PMV_VOL_OFS[1], 8'h00);
    // Speed field agreement and the one-bit override
    wrs(PMV_MIX_OFS[1], 8'h25);
    chkReg({6'h00, speed}, 8'h00);
    wr(PMV_MIX_OFS[0], 8'h25);
    wrs(PMV_MIX_OFS[2], 8'h25);
    chkReg({6'h00, speed}, 8'h01);
    wrs(PMV_MIX_OFS[1], 8'h27);
    chkReg({5'h00, oneBit, speed}, 8'h07);
    for (int s = 2; s >= 0; s--)
    begin
      for (int p = 0; p < 3; p++) wr(PMV_MIX_OFS[p], 8'h24 | 8'(s));
      @(negedge core_clk);
      chkReg({5'h00, oneBit, speed}, 8'(s));
    end
    // Soft ramp: 1 dB after 8 frames, then target, then slow silence
    wr(PMV_MODE3_OFS, 8'h80);
    wr(PMV_VOL_OFS[3], 8'd20);
    frames(8);
    chkSmp(outB[1], 2674, 60);
    frames(170);
    chkSmp(outB[1], 300, 2);
    wr(PMV_VOL_OFS[3], 8'h80);
    frames(1);
    chkSmp(outB[1], 300, 10);
    // Zero cross: hold until the sign flips, else until the timeout
    wr(PMV_MODE3_OFS, 8'h40);
    wr(PMV_VOL_OFS[1], 8'd20);
    frames(4);
    chkSmp(outB[0], 3000, 2);
    rightVal <= 24'hfff448;
    frames(3);
    chkSmp(outB[0], -300, 2);
    wr(PMV_VOL_OFS[1], 8'h00);
    frames(505);
    chkSmp(outB[0], -300, 2);
    frames(525);
    chkSmp(outB[0], -3000, 2);
    // Mid-run reset clears a silenced channel and its pin
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    chkRd(PMV_VOL_OFS[3], 8'h00);
    chkReg({2'b00, mutePin}, 8'h00);
    finish_test();
  end

  // Hang guard, well above the roughly 5100 cycles needed
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end
endmodule : testbench
